/* design/flx_exec.sv */
// Purpose: issue and execute of loads, alu ops, c copies, swap and transmit function
// Assumes: instruction held stable at issue until accepted; operand right aligned
// Notes:   interlocks use per-register free countdowns
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - lower A const load, high half zeroed
// - 022/023 load full 32-bit constant into A
// - full constant: issue 5, register free 3
// - 024-027 load A from channel data
// - channel loads ignore busy; issue 1, free 3
// - 030 upper B constant, low zeroed
// - 031 lower B constant, high zeroed
// - half constant loads: issue 3, free 3
// - 032/033 full constant into B
// - 034-037 load B from channel data
// - 040 B gets A plus B
// - 041 B gets B minus A
// - add/sub: issue 1, A 1, B 4
// - C register; 042 copies B to C
// - 043 copies C to B
// - C copies need B,C free; 1 period
// - 044-046 and, xor, or into B
// - logic ops and swap: all 1 period
// - 047 exchanges A and B
// - 050-053 pulse, then A word, B word
// - busy set until response, then stored
// - transmit needs A,B free; issue 1
module flx_exec
  import flx_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        arst_n_in,
  input  wire flx_instr_s  instr_in,
  output logic             instr_ready_out,
  output flx_tx_s          tx_out,
  input  wire flx_rsp_s    rsp_in,
  output logic [FLX_W-1:0] reg_a_out,
  output logic [FLX_W-1:0] reg_b_out,
  output logic [FLX_W-1:0] reg_c_out,
  output logic [FLX_NCH-1:0] chan_busy_out
);

  // ****************************************************************
  // opcode decode
  // ****************************************************************
  function automatic logic in_grp(input logic [5:0] op, input logic [5:0] base);
    in_grp = (op[5:2] == base[5:2]);
  endfunction : in_grp

  logic [5:0] op;
  logic       is_lla, is_load_a_full_const, is_lac, is_lub, is_llb, is_load_b_full_const, is_lbc;
  logic       is_add, is_sub, is_cfb, is_bfc, is_and, is_xor, is_ior, is_swp, is_tf;
  logic       is_known;

  assign op      = instr_in.opcode;
  assign is_lla  = (op == OP_LLA);
  assign is_load_a_full_const = (op == OP_LOAD_A_FULL_CONST_0) || (op == OP_LOAD_A_FULL_CONST_1);
  assign is_lac  = in_grp(op, OP_LAC_BASE);
  assign is_lub  = (op == OP_LUB);
  assign is_llb  = (op == OP_LLB);
  assign is_load_b_full_const = (op == OP_LOAD_B_FULL_CONST_0) || (op == OP_LOAD_B_FULL_CONST_1);
  assign is_lbc  = in_grp(op, OP_LBC_BASE);
  assign is_add  = (op == OP_ADD);
  assign is_sub  = (op == OP_SUB);
  assign is_cfb  = (op == OP_C_FROM_B);
  assign is_bfc  = (op == OP_B_FROM_C);
  assign is_and  = (op == OP_AND);
  assign is_xor  = (op == OP_XOR);
  assign is_ior  = (op == OP_IOR);
  assign is_swp  = (op == OP_SWAP);
  assign is_tf   = in_grp(op, OP_TF_BASE);

  assign is_known = is_lla | is_load_a_full_const | is_lac | is_lub | is_llb | is_load_b_full_const | is_lbc
                  | is_add | is_sub | is_cfb | is_bfc | is_and | is_xor | is_ior
                  | is_swp | is_tf;

  // ****************************************************************
  // issue conditions and latencies
  // ****************************************************************
  logic       free_a, free_b, free_c;
  logic       need_a, need_b, need_c;
  logic       issue_gap_free;
  logic       can_issue, issue;
  logic [FLX_CNT_W-1:0] gap_q, gap_d, issue_lat;
  logic [FLX_CNT_W-1:0] lat_a, lat_b, lat_c;
  logic       ld_a, ld_b, ld_c;

  // which registers must be free; channel loads never look at busy
  assign need_a = is_lla | is_load_a_full_const | is_lac | is_add | is_sub | is_and | is_xor
                | is_ior | is_swp | is_tf;
  assign need_b = is_lub | is_llb | is_load_b_full_const | is_lbc | is_add | is_sub | is_cfb
                | is_bfc | is_and | is_xor | is_ior | is_swp | is_tf;
  assign need_c = is_cfb | is_bfc;

  assign issue_gap_free = (gap_q == T_ZERO);
  assign can_issue = issue_gap_free && (!need_a || free_a) && (!need_b || free_b)
                   && (!need_c || free_c);
  // unknown opcodes are accepted and dropped so the stream never wedges
  assign instr_ready_out = can_issue || !is_known;
  assign issue = instr_in.valid && is_known && can_issue;

  // next-issue spacing: constants 3 or 5, everything else 1
  assign issue_lat = (is_load_a_full_const | is_load_b_full_const) ? T_FIVE
                   : (is_lla | is_lub | is_llb) ? T_THREE
                   : T_ONE;

  // register free latencies
  assign lat_a = (is_lla | is_load_a_full_const | is_lac) ? T_THREE : T_ONE;
  assign lat_b = (is_add | is_sub) ? T_FOUR
               : (is_lub | is_llb | is_load_b_full_const | is_lbc) ? T_THREE : T_ONE;
  assign lat_c = T_ONE;
  assign ld_a  = issue && need_a;
  assign ld_b  = issue && need_b;
  assign ld_c  = issue && need_c;

  assign gap_d = issue ? FLX_CNT_W'(issue_lat - T_ONE)
               : issue_gap_free ? T_ZERO : FLX_CNT_W'(gap_q - T_ONE);

  flx_free_cnt u_free_a (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .load_in    (ld_a),
    .value_in   (lat_a),
    .free_out   (free_a)
  );
  flx_free_cnt u_free_b (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .load_in    (ld_b),
    .value_in   (lat_b),
    .free_out   (free_b)
  );
  flx_free_cnt u_free_c (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .load_in    (ld_c),
    .value_in   (lat_c),
    .free_out   (free_c)
  );

  // ****************************************************************
  // datapath
  // ****************************************************************
  logic [FLX_W-1:0]    a_q, a_d, b_q, b_d, c_q, c_d, chan_word;
  logic [FLX_HALF-1:0] k16;
  logic [1:0]          sel_ch;
  logic                tf_go;
  flx_tx_s             tx_q, tx_d;

  assign k16    = instr_in.operand[FLX_HALF-1:0];
  assign sel_ch = op[1:0];  // low opcode bits pick the channel

  // register next values
  assign a_d = !issue  ? a_q
             : is_lla  ? {{FLX_HALF{1'b0}}, k16}
             : is_load_a_full_const ? instr_in.operand
             : is_lac  ? chan_word
             : is_swp  ? b_q
             : a_q;
  assign b_d = !issue  ? b_q
             : is_lub  ? {k16, {FLX_HALF{1'b0}}}
             : is_llb  ? {{FLX_HALF{1'b0}}, k16}
             : is_load_b_full_const ? instr_in.operand
             : is_lbc  ? chan_word
             : is_add  ? FLX_W'(b_q + a_q)
             : is_sub  ? FLX_W'(b_q - a_q)
             : is_bfc  ? c_q
             : is_and  ? (a_q & b_q)
             : is_xor  ? (a_q ^ b_q)
             : is_ior  ? (a_q | b_q)
             : is_swp  ? a_q
             : b_q;
  assign c_d = (issue && is_cfb) ? b_q : c_q;

  // transmit function: pulse with function word from A then B word
  assign tf_go = issue && is_tf;
  assign tx_d  = '{pulse: tf_go, chan: sel_ch, func_word: tf_go ? a_q : tx_q.func_word,
                   data_word: tf_go ? b_q : tx_q.data_word};

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      a_q   <= '0;
      b_q   <= '0;
      c_q   <= '0;
      gap_q <= T_ZERO;
      tx_q  <= '0;
    end else begin
      a_q   <= a_d;
      b_q   <= b_d;
      c_q   <= c_d;
      gap_q <= gap_d;
      tx_q  <= tx_d;
    end
  end

  flx_chan_bank #(.NCH(FLX_NCH)) u_chan (
    .ref_clk_in   (ref_clk_in),
    .arst_n_in    (arst_n_in),
    .send_in      (tf_go),         // busy set at issue, no wait for reply
    .send_chan_in (sel_ch),
    .rsp_in       (rsp_in),
    .rd_chan_in   (sel_ch),
    .rd_data_out  (chan_word),
    .busy_out     (chan_busy_out)
  );

  assign tx_out    = tx_q;
  assign reg_a_out = a_q;
  assign reg_b_out = b_q;
  assign reg_c_out = c_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_lla_low_half: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (issue && is_lla) |=> a_q == {{FLX_HALF{1'b0}}, $past(instr_in.operand[15:0])})
    else $error("lower A load wrong");
  a_full_gap: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (issue && (is_load_a_full_const || is_load_b_full_const)) |=> !issue [*4] ##1 1)
    else $error("full constant issued early");
  a_half_gap: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (issue && (is_lub || is_llb || is_lla)) |=> !issue [*2])
    else $error("half constant issued early");
  a_chan_load: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (issue && is_lbc) |=> b_q == $past(chan_word))
    else $error("channel load into B wrong");
  a_sub_result: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (issue && is_sub) |=> b_q == FLX_W'($past(b_q) - $past(a_q)))
    else $error("subtract wrong");
  a_addsub_bfree: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (issue && (is_add || is_sub)) |=> !free_b [*3] ##1 free_b)
    else $error("B free timing after add wrong");
  a_c_copy: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (issue && is_cfb) |=> c_q == $past(b_q) && free_c)
    else $error("C copy wrong");
  a_swap_pair: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (issue && is_swp) |=> a_q == $past(b_q) && b_q == $past(a_q))
    else $error("swap wrong");
  a_tf_words: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (issue && is_tf) |=> tx_out.pulse && tx_out.func_word == $past(a_q)
      && tx_out.data_word == $past(b_q) && chan_busy_out[$past(sel_ch)])
    else $error("transmit function wrong");
  a_hold_busy: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (instr_in.valid && is_known && need_a && !free_a) |-> !issue)
    else $error("issued while A busy");

endmodule : flx_exec
`default_nettype wire

/* design/flx_pkg.sv */
// Purpose: shared constants and types for the foreground load/alu execution block
// Assumes: 100 MHz processor clock, octal opcodes in a 6-bit field
// Notes:   latencies are counted in processor clock periods
package flx_pkg;

  // ****************************************************************
  // widths and clock
  // ****************************************************************
  localparam int          FLX_CLK_NS   = 10;
  localparam int          FLX_W        = 32;
  localparam int          FLX_HALF     = 16;
  localparam int          FLX_NCH      = 4;
  localparam int          FLX_CNT_W    = 3;

  // ****************************************************************
  // opcodes (octal)
  // ****************************************************************
  localparam logic [5:0]  OP_LLA       = 6'o21;
  localparam logic [5:0]  OP_LOAD_A_FULL_CONST_0    = 6'o22;
  localparam logic [5:0]  OP_LOAD_A_FULL_CONST_1    = 6'o23;
  localparam logic [5:0]  OP_LAC_BASE  = 6'o24;
  localparam logic [5:0]  OP_LUB       = 6'o30;
  localparam logic [5:0]  OP_LLB       = 6'o31;
  localparam logic [5:0]  OP_LOAD_B_FULL_CONST_0    = 6'o32;
  localparam logic [5:0]  OP_LOAD_B_FULL_CONST_1    = 6'o33;
  localparam logic [5:0]  OP_LBC_BASE  = 6'o34;
  localparam logic [5:0]  OP_ADD       = 6'o40;
  localparam logic [5:0]  OP_SUB       = 6'o41;
  localparam logic [5:0]  OP_C_FROM_B  = 6'o42;
  localparam logic [5:0]  OP_B_FROM_C  = 6'o43;
  localparam logic [5:0]  OP_AND       = 6'o44;
  localparam logic [5:0]  OP_XOR       = 6'o45;
  localparam logic [5:0]  OP_IOR       = 6'o46;
  localparam logic [5:0]  OP_SWAP      = 6'o47;
  localparam logic [5:0]  OP_TF_BASE   = 6'o50;
  localparam logic [3:0]  OP_GRP_MASK  = 4'hf;

  // ****************************************************************
  // timing in clock periods
  // ****************************************************************
  localparam logic [FLX_CNT_W-1:0] T_ONE   = 3'h1;
  localparam logic [FLX_CNT_W-1:0] T_THREE = 3'h3;
  localparam logic [FLX_CNT_W-1:0] T_FOUR  = 3'h4;
  localparam logic [FLX_CNT_W-1:0] T_FIVE  = 3'h5;
  localparam logic [FLX_CNT_W-1:0] T_ZERO  = 3'h0;

  // ****************************************************************
  // types
  // ****************************************************************
  // instruction presented at the issue position
  typedef struct packed {
    logic                 valid;
    logic [5:0]           opcode;
    logic [FLX_W-1:0]     operand;  // parcels following opcode, right aligned
  } flx_instr_s;

  // function transmission towards the channel loop
  typedef struct packed {
    logic                 pulse;
    logic [1:0]           chan;
    logic [FLX_W-1:0]     func_word;
    logic [FLX_W-1:0]     data_word;
  } flx_tx_s;

  // response returned from the channel loop
  typedef struct packed {
    logic                 valid;
    logic [1:0]           chan;
    logic [FLX_W-1:0]     word;
  } flx_rsp_s;

  typedef enum logic [1:0] {
    FLX_REG_A,
    FLX_REG_B,
    FLX_REG_C
  } flx_reg_e;

endpackage : flx_pkg

/* design/flx_free_cnt.sv */
// Purpose: one register-free countdown of the issue stage
// Assumes: load wins over count-down
// Notes:   free when the count is zero
`timescale 1ns/10ps
`default_nettype none
module flx_free_cnt
  import flx_pkg::*;
(
  input  wire logic                 ref_clk_in,
  input  wire logic                 arst_n_in,
  input  wire logic                 load_in,
  input  wire logic [FLX_CNT_W-1:0] value_in,
  output logic                      free_out
);

  logic [FLX_CNT_W-1:0] cnt_q;
  logic [FLX_CNT_W-1:0] cnt_d;

  // a latency of n frees the register n cycles after issue
  assign cnt_d    = load_in ? FLX_CNT_W'(value_in - T_ONE)
                  : (cnt_q == T_ZERO) ? T_ZERO : FLX_CNT_W'(cnt_q - T_ONE);
  assign free_out = (cnt_q == T_ZERO);

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= T_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : flx_free_cnt
`default_nettype wire

/* design/flx_chan_bank.sv */
// Purpose: channel data registers and busy flags for four channels
// Assumes: at most one response per cycle
// Notes:   set of busy wins over a response clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
module flx_chan_bank
  import flx_pkg::*;
#(
  parameter int NCH = FLX_NCH
) (
  input  wire logic                 ref_clk_in,
  input  wire logic                 arst_n_in,
  input  wire logic                 send_in,
  input  wire logic [1:0]           send_chan_in,
  input  wire flx_rsp_s             rsp_in,
  input  wire logic [1:0]           rd_chan_in,
  output logic [FLX_W-1:0]          rd_data_out,
  output logic [NCH-1:0]            busy_out
);

  logic [FLX_W-1:0] data_q [NCH];
  logic [NCH-1:0]   busy_q;

  // read is a plain mux; busy never gates it
  assign rd_data_out = data_q[rd_chan_in];
  assign busy_out    = busy_q;

  // ****************************************************************
  // busy flags and response capture
  // ****************************************************************
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        data_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (send_in && send_chan_in == 2'(i)) begin
          busy_q[i] <= 1'b1;
        end else if (rsp_in.valid && rsp_in.chan == 2'(i) && busy_q[i]) begin
          busy_q[i] <= 1'b0;
        end
        if (rsp_in.valid && rsp_in.chan == 2'(i) && busy_q[i]) begin
          data_q[i] <= rsp_in.word;
        end
      end
    end
  end

  a_rsp_clears_busy: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (rsp_in.valid && busy_q[rsp_in.chan] && !(send_in && send_chan_in == rsp_in.chan))
    |=> !busy_q[$past(rsp_in.chan)] && data_q[$past(rsp_in.chan)] == $past(rsp_in.word))
    else $error("response did not clear busy and store word");

endmodule : flx_chan_bank
`default_nettype wire

/* tb/flx_loop_node.sv */
// Purpose: behavioural ring of channel nodes answering function pulses
// Assumes: one pending function per channel; a newer pulse replaces it
// Notes:   idle reply word keeps toggling so a stale word never looks valid
`timescale 1ns/10ps
`default_nettype none
module flx_loop_node
  import flx_pkg::*;
(
  input  wire logic    ref_clk_in,
  input  wire logic    arst_n_in,
  input  wire flx_tx_s tx_in,
  input  wire logic    slow_in,
  output flx_rsp_s     rsp_out
);
  logic [FLX_NCH-1:0] pend_q;
  logic [4:0]         wait_q [FLX_NCH];
  logic [FLX_W-1:0]   word_q [FLX_NCH];
  logic               sent;

  // ****************************************************************
  // reply engine
  // ****************************************************************
  // one reply per cycle, lowest channel first; slow trips take the long way round
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pend_q  <= '0;
      rsp_out <= '0;
      for (int i = 0; i < FLX_NCH; i++) begin
        wait_q[i] <= '0;
        word_q[i] <= '0;
      end
    end else begin
      sent = 1'b0;
      rsp_out.valid <= 1'b0;
      rsp_out.word  <= ~rsp_out.word;  // released line shows no old value
      for (int i = 0; i < FLX_NCH; i++) begin
        if (pend_q[i] && wait_q[i] == 5'h0 && !sent) begin
          rsp_out.valid <= 1'b1;
          rsp_out.chan  <= 2'(i);
          rsp_out.word  <= word_q[i];
          pend_q[i]     <= 1'b0;
          sent = 1'b1;
        end else if (wait_q[i] != 5'h0) begin
          wait_q[i] <= wait_q[i] - 5'h1;
        end
      end
      // a node answers with a word built from both words it was sent
      if (tx_in.pulse) begin
        pend_q[tx_in.chan] <= 1'b1;
        wait_q[tx_in.chan] <= slow_in ? 5'(17 + tx_in.chan) : 5'h1;
        word_q[tx_in.chan] <= tx_in.func_word ^ {tx_in.data_word[15:0], tx_in.data_word[31:16]};
      end
    end
  end
endmodule : flx_loop_node
`default_nettype wire

/* tb/foreground_load_alu_exec_test.sv */
// Purpose: self-checking bench for the load/alu execution block
// Assumes: reference model predicts ready, registers, pulses and busy flags
// Notes:   outputs compared at the falling edge, inputs driven 1 ns after rising
`timescale 1ns/10ps
`default_nettype none
module foreground_load_alu_exec_test;
  import flx_pkg::*;
  logic               ref_clk_in;
  logic               arst_n_in;
  logic               slow;
  flx_instr_s         instr;
  logic               instr_ready;
  flx_tx_s            tx;
  flx_rsp_s           rsp;
  logic [FLX_W-1:0]   reg_a, reg_b, reg_c, ma, mb, mc;
  logic [FLX_W-1:0]   mch [FLX_NCH];
  logic [FLX_NCH-1:0] busy, mbusy, mset;
  flx_tx_s            mtx;
  logic               acc;
  int                 cnt_a, cnt_b, cnt_c, space, mismatches, cmp_count, seed;

  flx_exec flx_exec_inst (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .instr_in(instr),
    .instr_ready_out(instr_ready), .tx_out(tx), .rsp_in(rsp), .reg_a_out(reg_a),
    .reg_b_out(reg_b), .reg_c_out(reg_c), .chan_busy_out(busy));
  flx_loop_node flx_loop_node_inst (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .tx_in(tx), .slow_in(slow), .rsp_out(rsp));

  always #(FLX_CLK_NS / 2) ref_clk_in = ~ref_clk_in;

  // ****************************************************************
  // expectations
  // ****************************************************************
  // registers {c,b,a} that must be free before the opcode may issue
  function automatic logic [2:0] need_mask(input logic [5:0] op);
    case (op) inside
      [OP_LLA:6'o27]: need_mask = 3'b001;
      [OP_LUB:6'o37]: need_mask = 3'b010;
      OP_C_FROM_B, OP_B_FROM_C: need_mask = 3'b110;
      [OP_ADD:6'o53]: need_mask = 3'b011;
      default: need_mask = 3'b000;
    endcase
  endfunction : need_mask

  function automatic int issue_gap(input logic [5:0] op);
    case (op) inside
      OP_LOAD_A_FULL_CONST_0, OP_LOAD_A_FULL_CONST_1, OP_LOAD_B_FULL_CONST_0, OP_LOAD_B_FULL_CONST_1: issue_gap = 5;
      OP_LLA, OP_LUB, OP_LLB: issue_gap = 3;
      default: issue_gap = 1;
    endcase
  endfunction : issue_gap

  function automatic logic pred_ready(input logic [5:0] op);
    logic [2:0] m;
    m = need_mask(op);
    return space == 0 && !(m[0] && cnt_a != 0) && !(m[1] && cnt_b != 0) && !(m[2] && cnt_c != 0);
  endfunction : pred_ready

  // model steps on the rising edge with the values seen before it
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {ma, mb, mc, mbusy, mtx, cnt_a, cnt_b, cnt_c, space} = '0;
      for (int i = 0; i < FLX_NCH; i++) begin
        mch[i] = '0;
      end
    end else begin
      acc = instr.valid && pred_ready(instr.opcode);
      cnt_a = (cnt_a > 0) ? cnt_a - 1 : 0;
      cnt_b = (cnt_b > 0) ? cnt_b - 1 : 0;
      cnt_c = (cnt_c > 0) ? cnt_c - 1 : 0;
      space = (space > 0) ? space - 1 : 0;
      mtx.pulse = 1'b0;
      mset = '0;
      if (acc) begin
        space = issue_gap(instr.opcode) - 1;
        case (instr.opcode) inside
          OP_LLA: {ma, cnt_a} = {16'h0, instr.operand[15:0], 32'd2};
          OP_LOAD_A_FULL_CONST_0, OP_LOAD_A_FULL_CONST_1: {ma, cnt_a} = {instr.operand, 32'd2};
          [OP_LAC_BASE:6'o27]: {ma, cnt_a} = {mch[instr.opcode[1:0]], 32'd2};
          OP_LUB: {mb, cnt_b} = {instr.operand[15:0], 16'h0, 32'd2};
          OP_LLB: {mb, cnt_b} = {16'h0, instr.operand[15:0], 32'd2};
          OP_LOAD_B_FULL_CONST_0, OP_LOAD_B_FULL_CONST_1: {mb, cnt_b} = {instr.operand, 32'd2};
          [OP_LBC_BASE:6'o37]: {mb, cnt_b} = {mch[instr.opcode[1:0]], 32'd2};
          OP_ADD: {mb, cnt_b} = {mb + ma, 32'd3};
          OP_SUB: {mb, cnt_b} = {mb - ma, 32'd3};
          OP_C_FROM_B: mc = mb;
          OP_B_FROM_C: mb = mc;
          OP_AND: mb = mb & ma;
          OP_XOR: mb = mb ^ ma;
          OP_IOR: mb = mb | ma;
          OP_SWAP: {ma, mb} = {mb, ma};
          [OP_TF_BASE:6'o53]: begin
            mtx = {1'b1, instr.opcode[1:0], ma, mb};
            mset[instr.opcode[1:0]] = 1'b1;
          end
          default: ;
        endcase
      end
      // a fresh transmit on the same channel wins over a reply in that cycle
      // the word still lands while busy; only the clear loses to the new transmit
      if (rsp.valid && mbusy[rsp.chan]) begin
        mch[rsp.chan] = rsp.word;
        mbusy[rsp.chan] = mset[rsp.chan];
      end
      mbusy = mbusy | mset;
    end
  end

  task automatic check(input logic [FLX_W-1:0] seen, input logic [FLX_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // outputs are settled by the falling edge
  always @(negedge ref_clk_in) begin
    if (instr.valid) begin
      check(32'(instr_ready), 32'(pred_ready(instr.opcode)));
    end
    check(reg_a, ma);
    check(reg_b, mb);
    check(reg_c, mc);
    check(32'(tx.pulse), 32'(mtx.pulse));
    if (mtx.pulse) begin
      check(tx.func_word, mtx.func_word);
      check(32'(tx.chan), 32'(mtx.chan));
      check(tx.data_word, mtx.data_word);
    end
    check(32'(busy), 32'(mbusy));
  end

  // ****************************************************************
  // stimulus
  // ****************************************************************
  task automatic results();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // holds the instruction until the edge that takes it
  task automatic issue(input logic [5:0] op, input logic [FLX_W-1:0] opd);
    int n;
    logic ok;
    instr = {1'b1, op, (issue_gap(op) == 3) ? {16'h0, opd[15:0]} : opd};
    // ready is read while settled, so the edge that takes the request ends the wait
    for (n = 0; n < 40; n++) begin
      @(negedge ref_clk_in);
      ok = (instr_ready === 1'b1);
      @(posedge ref_clk_in);
      #1;
      if (ok) break;
    end
    if (n == 40) begin
      mismatches++;
      results();
    end
  endtask : issue

  task automatic idle(input int k);
    instr.valid = 1'b0;
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask : idle

  task automatic run_random(input int n);
    for (int i = 0; i < n; i++) begin
      slow = 1'($urandom_range(1));
      issue(6'($urandom_range(43, 17)), $urandom());
      if ($urandom_range(3) == 0) idle(1 + $urandom_range(5));
    end
  endtask : run_random

  initial begin
    {ref_clk_in, arst_n_in, slow, instr, mismatches, cmp_count} = '0;
    seed = $urandom(29296);
    repeat (16) @(posedge ref_clk_in);
    #1 arst_n_in = 1'b1;
    // long constant spacing, then add/sub holding b for four periods
    issue(OP_LOAD_A_FULL_CONST_0, 32'h8000_0001);
    issue(OP_ADD, 32'h0);
    issue(OP_AND, 32'h0);
    issue(OP_LOAD_B_FULL_CONST_1, 32'hffff_ffff);
    issue(OP_SUB, 32'h0);
    issue(OP_SWAP, 32'h0);
    // channel load right behind a slow transmit sees the old word
    slow = 1'b1;
    issue(OP_TF_BASE, 32'h0);
    issue(OP_LAC_BASE, 32'h0);
    idle(25);
    issue(OP_LBC_BASE, 32'h0);
    for (int op = 17; op <= 43; op++) begin
      issue(6'(op), $urandom());
    end
    run_random(1500);
    // second reset in mid-run
    idle(1);
    arst_n_in = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1 arst_n_in = 1'b1;
    run_random(1500);
    idle(60);
    results();
  end
endmodule : foreground_load_alu_exec_test
`default_nettype wire
